// ### fpf_divider.sv
// Purpose: Shared constants and types, plus the shift clock divider
// Assumes: clk is the internal dot clock; the divide setting is held stable between frames
// Notes:   A divide exponent of zero gives a clock at the full dot clock rate

// ****************************************************************
// Package
// ****************************************************************
package fpf_pkg;
  // I/O ports of the indexed extension registers
  localparam logic [15:0] IO_INDEX_ADDR    = 16'h03d0;
  localparam logic [15:0] IO_DATA_ADDR     = 16'h03d1;
  localparam logic [7:0]  IDX_FORMAT_ZERO  = 8'h10;
  localparam logic [7:0]  IDX_FORMAT_ONE   = 8'h11;
  // Field positions
  localparam int          FZ_RSVD_BIT      = 7;
  localparam int          FZ_DIV_LSB       = 4;
  localparam int          FZ_COLOR_LSB     = 2;
  localparam int          FZ_TYPE_LSB      = 0;
  localparam int          FO_RESTRICT_BIT  = 7;
  localparam int          FO_BPC_LSB       = 4;
  localparam int          FO_DITHER_LSB    = 2;
  localparam int          FO_FRC_LSB       = 0;
  // Reset values
  localparam logic [7:0]  FORMAT_ZERO_RST  = 8'h00;
  localparam logic [7:0]  FORMAT_ONE_RST   = 8'h00;
  localparam logic [7:0]  INDEX_RST        = 8'h00;
  // Grey weights, scaled by 256
  localparam logic [7:0]  NTSC_W_R         = 8'h4d;
  localparam logic [7:0]  NTSC_W_G         = 8'h96;
  localparam logic [7:0]  NTSC_W_B         = 8'h1d;
  localparam logic [7:0]  EQUAL_W          = 8'h55;
  // Divider sizing and dither level exponent step
  localparam int          DIV_CNT_W        = 4;
  localparam logic [2:0]  DIV_EXP_MAX      = 3'h4;
  localparam logic [3:0]  DITHER_EXTRA     = 4'h2;

  typedef enum logic [1:0] {
    COLOR_NTSC  = 2'h0,
    COLOR_EQUAL = 2'h1,
    COLOR_GREEN = 2'h2,
    COLOR_PANEL = 2'h3
  } fpf_color_sel_t;

  typedef enum logic [1:0] {
    PT_SINGLE = 2'h0,
    PT_RSVD1  = 2'h1,
    PT_RSVD2  = 2'h2,
    PT_DUAL   = 2'h3
  } fpf_panel_type_t;

  typedef enum logic [1:0] {
    FRC_NONE  = 2'h0,
    FRC_16    = 2'h1,
    FRC_2     = 2'h2,
    FRC_RSVD  = 2'h3
  } fpf_frc_t;

  typedef enum logic [1:0] {
    DITHER_OFF  = 2'h0,
    DITHER_2BIT = 2'h1,
    DITHER_RSV4 = 2'h2,
    DITHER_RSV  = 2'h3
  } fpf_dither_t;

  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } fpf_rgb_t;

  typedef struct packed {
    logic [2:0]      div;
    fpf_color_sel_t  color;
    fpf_panel_type_t ptype;
    logic            restrict_dither;
    logic [2:0]      bpc;
    fpf_dither_t     dither;
    fpf_frc_t        frc;
  } fpf_cfg_t;

  typedef struct packed {
    logic is_stn;
    logic frame_accel;
    logic pack4;
  } fpf_tech_t;
endpackage

`timescale 1ns/1ps

// ****************************************************************
// Shift clock divider
// ****************************************************************
module fpf_divider #(
  parameter int CNT_W = fpf_pkg::DIV_CNT_W
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Setting
  input  wire logic [2:0] div_exp,
  input  wire logic       div_ok,
  input  wire logic       restart,
  // Shift clock
  output logic            shift_level_ff,
  output logic            shift_pulse_ff
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             level;
    logic             pulse;
  } fpf_div_st_t;

  fpf_div_st_t st_ff;
  fpf_div_st_t nxt_st;
  logic [CNT_W-1:0] period_m1;

  always_comb
  begin
    period_m1 = CNT_W'((1 << div_exp) - 1);
    nxt_st    = st_ff;
    if (!div_ok)
    begin
      // Undefined setting parks the clock low
      nxt_st = '0;
    end
    else
    begin
      if (restart)
        nxt_st.cnt = '0;
      else
        nxt_st.cnt = (st_ff.cnt + CNT_W'(1)) & period_m1;
      nxt_st.pulse = (nxt_st.cnt == '0);
      nxt_st.level = (div_exp == 3'h0) || (nxt_st.cnt <= (period_m1 >> 1));
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign shift_level_ff = st_ff.level;
  assign shift_pulse_ff = st_ff.pulse;

  AST_DIV2_PERIOD: assert property (@(posedge clk) disable iff (!arst_n)
    (shift_pulse_ff && div_ok && div_exp == 3'h1 && !restart)[*2] |-> 1'b0
  ) else $error("Divide by two pulse held for two cycles");

  AST_DIV_BAD_LOW: assert property (@(posedge clk) disable iff (!arst_n)
    !div_ok |=> !shift_level_ff && !shift_pulse_ff
  ) else $error("Shift clock not parked on bad setting");
endmodule // fpf_divider

// ### fpf_format_select.sv
// Purpose: Flat panel format registers, grey reduction and shift clock control
// Assumes: clk is the internal dot clock at 25 MHz; frame_start comes from timing logic on clk
// Notes:   Settings written by software take effect at the next frame_start
//
// Notes on behaviour
// - Colour select: NTSC, equal, green-only grey reduction, or colour panel.
// - Monochrome panels get colour pixels reduced to grey by selected weighting.
// - Panel type 00 single drive, 11 dual drive; 01 and 10 reserved.
// - Mono TFT divide codes 000-100 give dot clock over 1 to 16.
// - Colour TFT divide codes 000 and 001 give dot clock over 1 and 2.
// - 4-bit packed colour single drive STN: codes 000-010 divide by 1, 2, 4.
// - Mono dual drive with acceleration: codes 000-011 divide by 1 to 8.
// - Mono dual drive without acceleration: codes 001-100 divide by 2 to 16.
// - 4-bit colour dual drive with acceleration: codes 000, 001 divide by 1, 2.
// - 4-bit colour dual drive without acceleration: codes 001, 010 divide by 2, 4.
// - 3-bit colour dual drive with acceleration: codes 000-010 divide by 1, 2, 4.
// - 3-bit colour dual drive without acceleration: codes 001-011 divide by 2, 4, 8.
// - Restrict bit set allows dithering only in modes above 256 colours.
// - Bits-per-colour codes 000-110 keep 0-6 MSBs; 111 keeps 8.
// - Without dithering, theoretical levels per channel are two to the X.
// - With 2-bit dithering, theoretical levels are four times two to the X.
// - FRC field: 00 none, 01 16-frame, 10 2-frame, 11 reserved.
// - Dither field: 00 off, 01 2-bit dithering, others reserved.

`timescale 1ns/1ps

module fpf_format_select (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // Host I/O port
  input  wire logic [15:0]      io_addr,
  input  wire logic             io_wr,
  input  wire logic             io_rd,
  input  wire logic [7:0]       io_wdata,
  output logic [7:0]            io_rdata_ff,
  // Panel technology and mode
  input  wire logic             panel_is_stn,
  input  wire logic             frame_accel_en,
  input  wire logic             pack_4bit,
  input  wire logic             high_color_mode,
  input  wire logic             frame_start,
  // Pixel stream
  input  wire logic             pix_valid,
  input  wire fpf_pkg::fpf_rgb_t pix_rgb,
  output logic                  pix_out_valid_ff,
  output fpf_pkg::fpf_rgb_t     pix_out_ff,
  // Panel side
  output logic                  panel_shift_clock_ff,
  output logic                  shift_pulse_ff,
  output logic                  div_valid_ff,
  output logic                  dual_drive_ff,
  output logic                  color_panel_ff,
  output logic                  dither_active_ff,
  output fpf_pkg::fpf_frc_t     frc_mode_ff,
  output logic [3:0]            level_exp_ff
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0]         idx;
    logic [7:0]         fmt_zero;
    logic [7:0]         fmt_one;
    fpf_pkg::fpf_cfg_t  act;
    fpf_pkg::fpf_tech_t tech;
    logic               load;
    logic               restart;
    logic [7:0]         rdata;
    logic               pix_valid;
    fpf_pkg::fpf_rgb_t  pix;
    logic               div_ok;
    logic [2:0]         div_exp;
    logic               dual;
    logic               color;
    logic               dither;
    fpf_pkg::fpf_frc_t  frc;
    logic [3:0]         level_exp;
  } fpf_st_t;

  fpf_st_t st_ff;
  fpf_st_t nxt_st;

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  // Number of MSBs kept per colour for a bits-per-colour code
  function automatic logic [3:0] bpc_bits(input logic [2:0] code);
    bpc_bits = (code == 3'h7) ? 4'h8 : {1'b0, code};
  endfunction

  function automatic logic [7:0] bpc_mask(input logic [2:0] code);
    bpc_mask = ~(8'hff >> bpc_bits(code));
  endfunction

  // Legal divide code range for the panel in use; exponent equals the code
  function automatic logic div_legal(input fpf_pkg::fpf_cfg_t c,
                                     input fpf_pkg::fpf_tech_t t);
    logic [2:0] lo;
    logic [2:0] hi;
    logic       col;
    lo  = 3'h0;
    hi  = fpf_pkg::DIV_EXP_MAX;
    col = (c.color == fpf_pkg::COLOR_PANEL);
    if (!t.is_stn)
      hi = col ? 3'h1 : fpf_pkg::DIV_EXP_MAX;
    else if (c.ptype != fpf_pkg::PT_DUAL)
      hi = col ? 3'h2 : fpf_pkg::DIV_EXP_MAX;
    else if (!col)
    begin
      lo = t.frame_accel ? 3'h0 : 3'h1;
      hi = t.frame_accel ? 3'h3 : 3'h4;
    end
    else if (t.pack4)
    begin
      lo = t.frame_accel ? 3'h0 : 3'h1;
      hi = t.frame_accel ? 3'h1 : 3'h2;
    end
    else
    begin
      lo = t.frame_accel ? 3'h0 : 3'h1;
      hi = t.frame_accel ? 3'h2 : 3'h3;
    end
    div_legal = (c.div >= lo) && (c.div <= hi);
  endfunction

  // Weighted grey from a colour pixel
  function automatic logic [7:0] grey_of(input fpf_pkg::fpf_rgb_t p,
                                         input fpf_pkg::fpf_color_sel_t sel);
    logic [15:0] acc;
    acc = 16'h0000;
    case (sel)
      fpf_pkg::COLOR_NTSC:
        acc = p.r * fpf_pkg::NTSC_W_R + p.g * fpf_pkg::NTSC_W_G
            + p.b * fpf_pkg::NTSC_W_B;
      fpf_pkg::COLOR_EQUAL:
        acc = (16'(p.r) + 16'(p.g) + 16'(p.b)) * 16'(fpf_pkg::EQUAL_W);
      default:
        acc = {p.g, 8'h00};
    endcase
    grey_of = acc[15:8];
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic              data_hit;
  logic [7:0]        grey;
  logic [7:0]        mask;
  fpf_pkg::fpf_cfg_t wcfg;

  always_comb
  begin
    nxt_st   = st_ff;
    data_hit = (io_addr == fpf_pkg::IO_DATA_ADDR);
    // Host register writes land in the software copy only
    if (io_wr && io_addr == fpf_pkg::IO_INDEX_ADDR)
      nxt_st.idx = io_wdata;
    if (io_wr && data_hit && st_ff.idx == fpf_pkg::IDX_FORMAT_ZERO)
      nxt_st.fmt_zero = io_wdata;
    if (io_wr && data_hit && st_ff.idx == fpf_pkg::IDX_FORMAT_ONE)
      nxt_st.fmt_one = io_wdata;
    if (io_rd)
    begin
      if (io_addr == fpf_pkg::IO_INDEX_ADDR)
        nxt_st.rdata = st_ff.idx;
      else if (data_hit && st_ff.idx == fpf_pkg::IDX_FORMAT_ZERO)
        nxt_st.rdata = st_ff.fmt_zero;
      else if (data_hit && st_ff.idx == fpf_pkg::IDX_FORMAT_ONE)
        nxt_st.rdata = st_ff.fmt_one;
      else
        nxt_st.rdata = 8'h00;
    end

    // Field split of the software copy
    wcfg.div             = st_ff.fmt_zero[fpf_pkg::FZ_DIV_LSB +: 3];
    wcfg.color           = fpf_pkg::fpf_color_sel_t'(st_ff.fmt_zero[fpf_pkg::FZ_COLOR_LSB +: 2]);
    wcfg.ptype           = fpf_pkg::fpf_panel_type_t'(st_ff.fmt_zero[fpf_pkg::FZ_TYPE_LSB +: 2]);
    wcfg.restrict_dither = st_ff.fmt_one[fpf_pkg::FO_RESTRICT_BIT];
    wcfg.bpc             = st_ff.fmt_one[fpf_pkg::FO_BPC_LSB +: 3];
    wcfg.dither          = fpf_pkg::fpf_dither_t'(st_ff.fmt_one[fpf_pkg::FO_DITHER_LSB +: 2]);
    wcfg.frc             = fpf_pkg::fpf_frc_t'(st_ff.fmt_one[fpf_pkg::FO_FRC_LSB +: 2]);

    // Mid-frame writes wait so a frame never mixes two settings
    // Restart waits a cycle so it meets the new divide code at the divider
    nxt_st.load    = frame_start;
    nxt_st.restart = st_ff.load;
    if (frame_start)
    begin
      nxt_st.act  = wcfg;
      nxt_st.tech = '{is_stn: panel_is_stn, frame_accel: frame_accel_en,
                      pack4: pack_4bit};
    end

    // Shift clock setting
    nxt_st.div_ok  = div_legal(st_ff.act, st_ff.tech);
    nxt_st.div_exp = st_ff.act.div;
    // Reserved type codes drive as single panel
    nxt_st.dual  = (st_ff.act.ptype == fpf_pkg::PT_DUAL);
    nxt_st.color = (st_ff.act.color == fpf_pkg::COLOR_PANEL);

    // Dithering and frame rate control
    nxt_st.dither = (st_ff.act.dither == fpf_pkg::DITHER_2BIT)
                 && (!st_ff.act.restrict_dither || high_color_mode);
    // Reserved FRC code is treated as none
    nxt_st.frc = (st_ff.act.frc == fpf_pkg::FRC_RSVD) ? fpf_pkg::FRC_NONE
               : st_ff.act.frc;
    nxt_st.level_exp = bpc_bits(st_ff.act.bpc)
                     + (nxt_st.dither ? fpf_pkg::DITHER_EXTRA : 4'h0);

    // Pixel path: one cycle of latency
    mask             = bpc_mask(st_ff.act.bpc);
    grey             = grey_of(pix_rgb, st_ff.act.color);
    nxt_st.pix_valid = pix_valid;
    if (pix_valid)
    begin
      if (st_ff.act.color == fpf_pkg::COLOR_PANEL)
        nxt_st.pix = '{r: pix_rgb.r & mask, g: pix_rgb.g & mask,
                       b: pix_rgb.b & mask};
      else
        nxt_st.pix = '{r: grey & mask, g: grey & mask, b: grey & mask};
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_ff          <= '0;
      st_ff.idx      <= fpf_pkg::INDEX_RST;
      st_ff.fmt_zero <= fpf_pkg::FORMAT_ZERO_RST;
      st_ff.fmt_one  <= fpf_pkg::FORMAT_ONE_RST;
    end
    else
      st_ff <= nxt_st;
  end

  // ****************************************************************
  // Shift clock divider
  // ****************************************************************
  fpf_divider #(
    .CNT_W (fpf_pkg::DIV_CNT_W)
  ) u_div (
    .clk            (clk),
    .arst_n         (arst_n),
    .div_exp        (st_ff.div_exp),
    .div_ok         (st_ff.div_ok),
    .restart        (st_ff.restart),
    .shift_level_ff (panel_shift_clock_ff),
    .shift_pulse_ff (shift_pulse_ff)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign io_rdata_ff      = st_ff.rdata;
  assign pix_out_valid_ff = st_ff.pix_valid;
  assign pix_out_ff       = st_ff.pix;
  assign div_valid_ff     = st_ff.div_ok;
  assign dual_drive_ff    = st_ff.dual;
  assign color_panel_ff   = st_ff.color;
  assign dither_active_ff = st_ff.dither;
  assign frc_mode_ff      = st_ff.frc;
  assign level_exp_ff     = st_ff.level_exp;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  AST_CFG_FRAME_ONLY: assert property (
    !frame_start |=> $stable(st_ff.act)
  ) else $error("Active setting changed outside frame start");

  AST_SHIFT_PARKED: assert property (
    !div_valid_ff ##1 !div_valid_ff |-> !panel_shift_clock_ff
  ) else $error("Shift clock moving on undefined divide code");

  AST_DUAL_TYPE: assert property (
    !frame_start ##1 1'b1 |-> dual_drive_ff == (st_ff.act.ptype == fpf_pkg::PT_DUAL)
  ) else $error("Dual drive output disagrees with panel type");

  AST_GREEN_ONLY: assert property (
    pix_valid && !frame_start && st_ff.act.color == fpf_pkg::COLOR_GREEN
    |=> pix_out_valid_ff && pix_out_ff.b == ($past(pix_rgb.g) & bpc_mask(st_ff.act.bpc))
  ) else $error("Green only reduction wrong");

  AST_COLOR_MASK: assert property (
    pix_valid && st_ff.act.color == fpf_pkg::COLOR_PANEL && st_ff.act.bpc == 3'h3
    && !frame_start |=> pix_out_ff.r[4:0] == 5'h00 && pix_out_ff.r[7:5] == $past(pix_rgb.r[7:5])
  ) else $error("Three bit colour mask wrong");

  AST_DITHER_RESTRICT: assert property (
    st_ff.act.restrict_dither && !high_color_mode |=> !dither_active_ff
  ) else $error("Dither active in low colour mode");

  AST_DITHER_ON: assert property (
    st_ff.act.dither == fpf_pkg::DITHER_2BIT && !st_ff.act.restrict_dither
    |=> dither_active_ff
  ) else $error("Dither not enabled");

  AST_LEVELS: assert property (
    1'b1 |=> level_exp_ff == bpc_bits($past(st_ff.act.bpc))
                            + (dither_active_ff ? 4'h2 : 4'h0)
  ) else $error("Theoretical level exponent wrong");

  AST_FRC_RSVD: assert property (
    st_ff.act.frc == fpf_pkg::FRC_RSVD |=> frc_mode_ff == fpf_pkg::FRC_NONE
  ) else $error("Reserved FRC code not treated as none");

  COV_DUAL_FRAME: cover property (frame_start ##2 dual_drive_ff && div_valid_ff);
  COV_DITHER: cover property (dither_active_ff && frc_mode_ff == fpf_pkg::FRC_16);
  COV_DIV16: cover property (st_ff.div_exp == 3'h4 && div_valid_ff && shift_pulse_ff);
endmodule // fpf_format_select

// ### fpf_panel_model.sv
// Purpose: Flat panel stand-in that counts shift clock activity
// Assumes: Panel pins are sampled on the dot clock
// Notes:   Counts rather than edges, so divider phase does not matter
`timescale 1ns/1ps

// ****************************************************************
// Panel model
// ****************************************************************
module fpf_panel_model (
  // Clock
  input  wire logic       clk,
  // Panel pins
  input  wire logic       shift_clock,
  input  wire logic       shift_pulse,
  // Count window
  input  wire logic       clr,
  output logic [7:0]      pulse_cnt_ff,
  output logic [7:0]      high_cnt_ff
);
  always @(posedge clk)
  begin
    if (clr)
    begin
      pulse_cnt_ff <= 8'h00;
      high_cnt_ff  <= 8'h00;
    end
    else
    begin
      pulse_cnt_ff <= pulse_cnt_ff + {7'h00, shift_pulse};
      high_cnt_ff  <= high_cnt_ff + {7'h00, shift_clock};
    end
  end
endmodule // fpf_panel_model

// ### testbench.sv
// Purpose: Self-checking bench for the flat panel format select block
// Assumes: Dot clock 25 MHz; settings go live two edges after frame_start
// Notes:   Shift clock is judged over a fixed 64-cycle count window
`timescale 1ns/1ps

module testbench;
  logic               clk;
  logic               arst_n;
  logic [15:0]        io_addr;
  logic               io_wr;
  logic               io_rd;
  logic [7:0]         io_wdata;
  logic [7:0]         io_rdata_ff;
  logic               panel_is_stn;
  logic               frame_accel_en;
  logic               pack_4bit;
  logic               high_color_mode;
  logic               frame_start;
  logic               pix_valid;
  fpf_pkg::fpf_rgb_t  pix_rgb;
  logic               pix_out_valid_ff;
  fpf_pkg::fpf_rgb_t  pix_out_ff;
  logic               shift_clock;
  logic               shift_pulse;
  logic               div_valid;
  logic               dual_drive;
  logic               color_panel;
  logic               dither_active;
  fpf_pkg::fpf_frc_t  frc_mode;
  logic [3:0]         level_exp;
  logic               cnt_clr;
  logic [7:0]         pulse_cnt;
  logic [7:0]         high_cnt;
  logic [7:0]         rd;
  int                 error_cnt;
  int                 n_compared;

  always #20 clk = ~clk;

  fpf_format_select u_dut (
    .clk(clk), .arst_n(arst_n), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata_ff(io_rdata_ff), .panel_is_stn(panel_is_stn),
    .frame_accel_en(frame_accel_en), .pack_4bit(pack_4bit),
    .high_color_mode(high_color_mode), .frame_start(frame_start),
    .pix_valid(pix_valid), .pix_rgb(pix_rgb), .pix_out_valid_ff(pix_out_valid_ff),
    .pix_out_ff(pix_out_ff), .panel_shift_clock_ff(shift_clock),
    .shift_pulse_ff(shift_pulse), .div_valid_ff(div_valid), .dual_drive_ff(dual_drive),
    .color_panel_ff(color_panel), .dither_active_ff(dither_active),
    .frc_mode_ff(frc_mode), .level_exp_ff(level_exp)
  );

  fpf_panel_model u_panel (
    .clk(clk), .shift_clock(shift_clock), .shift_pulse(shift_pulse), .clr(cnt_clr),
    .pulse_cnt_ff(pulse_cnt), .high_cnt_ff(high_cnt)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("errors %0d, comparisons %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Strobe drops on the next edge, so calls never collide in one step
  task automatic io_write(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    io_addr  <= a;
    io_wdata <= d;
    io_wr    <= 1'b1;
    @(posedge clk);
    io_wr <= 1'b0;
  endtask

  task automatic io_read(input logic [15:0] a);
    @(posedge clk);
    io_addr <= a;
    io_rd   <= 1'b1;
    @(posedge clk);
    io_rd <= 1'b0;
    #1;
    rd = io_rdata_ff;
  endtask

  task automatic reg_write(input logic [7:0] idx, input logic [7:0] d);
    io_write(fpf_pkg::IO_INDEX_ADDR, idx);
    io_write(fpf_pkg::IO_DATA_ADDR, d);
  endtask

  task automatic reg_read(input logic [7:0] idx);
    io_write(fpf_pkg::IO_INDEX_ADDR, idx);
    io_read(fpf_pkg::IO_DATA_ADDR);
  endtask

  task automatic apply(input logic [2:0] tech, input logic [7:0] f0, input logic [7:0] f1);
    reg_write(fpf_pkg::IDX_FORMAT_ZERO, f0);
    reg_write(fpf_pkg::IDX_FORMAT_ONE, f1);
    @(posedge clk);
    {panel_is_stn, frame_accel_en, pack_4bit} <= tech;
    frame_start <= 1'b1;
    @(posedge clk);
    frame_start <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask

  function automatic logic [7:0] keep(input logic [2:0] bpc, input logic [7:0] v);
    return v & ~(8'hff >> ((bpc == 3'h7) ? 4'h8 : {1'b0, bpc}));
  endfunction

  function automatic fpf_pkg::fpf_rgb_t want_pix(input logic [1:0] col, input logic [2:0] bpc,
                                                 input fpf_pkg::fpf_rgb_t p);
    logic [15:0] g;
    case (col)
      2'h0:    g = ({8'h00, fpf_pkg::NTSC_W_R} * {8'h00, p.r} + {8'h00, fpf_pkg::NTSC_W_G}
                    * {8'h00, p.g} + {8'h00, fpf_pkg::NTSC_W_B} * {8'h00, p.b}) >> 8;
      2'h1:    g = (({8'h00, p.r} + {8'h00, p.g} + {8'h00, p.b}) * 16'h0055) >> 8;
      default: g = {8'h00, p.g};
    endcase
    if (col == 2'h3)
      return {keep(bpc, p.r), keep(bpc, p.g), keep(bpc, p.b)};
    return {keep(bpc, g[7:0]), keep(bpc, g[7:0]), keep(bpc, g[7:0])};
  endfunction

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    reg_read(fpf_pkg::IDX_FORMAT_ZERO);
    check(24'(rd), 24'h000000);
    reg_read(fpf_pkg::IDX_FORMAT_ONE);
    check(24'(rd), 24'h000000);
    check(24'(div_valid), 24'h000001);
    check(24'({dual_drive, color_panel}), 24'h000000);
    check(24'({dither_active, frc_mode}), 24'h000000);
    check(24'(level_exp), 24'h000000);
  endtask

  // Stored values must not reach the outputs before a frame boundary
  task automatic t_regs();
    reg_write(fpf_pkg::IDX_FORMAT_ZERO, 8'hb7);
    reg_write(fpf_pkg::IDX_FORMAT_ONE, 8'ha6);
    reg_write(8'h12, 8'h33);
    reg_read(fpf_pkg::IDX_FORMAT_ZERO);
    check(24'(rd), 24'h0000b7);
    reg_read(fpf_pkg::IDX_FORMAT_ONE);
    check(24'(rd), 24'h0000a6);
    reg_read(8'h12);
    check(24'(rd), 24'h000000);
    io_read(16'h03d2);
    check(24'(rd), 24'h000000);
    check(24'({dual_drive, frc_mode}), 24'h000000);
    apply(3'h0, 8'hb7, 8'ha6);
    check(24'({dual_drive, frc_mode}), 24'h000006);
  endtask

  task automatic t_fields();
    logic [1:0] c;
    logic [3:0] x;
    for (int i = 0; i < 8; i++)
    begin
      c = i[1:0];
      x = (i == 7) ? 4'h8 : 4'(i);
      apply(3'h0, {4'h0, c, c}, {1'b0, i[2:0], c, c});
      check(24'(dual_drive), 24'(c == 2'h3));
      check(24'(color_panel), 24'(c == 2'h3));
      check(24'(frc_mode), 24'((c == 2'h3) ? 2'h0 : c));
      check(24'(dither_active), 24'(c == 2'h1));
      check(24'(level_exp), 24'(x + ((c == 2'h1) ? 4'h2 : 4'h0)));
    end
  endtask

  task automatic t_restrict();
    apply(3'h0, 8'h00, 8'hc4);
    check(24'({dither_active, level_exp}), 24'h000004);
    @(posedge clk);
    high_color_mode <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check(24'({dither_active, level_exp}), 24'h000016);
    @(posedge clk);
    high_color_mode <= 1'b0;
  endtask

  // Two pixels back to back through the same setting
  task automatic t_pix(input logic [1:0] col, input logic [2:0] bpc,
                       input fpf_pkg::fpf_rgb_t p1, input fpf_pkg::fpf_rgb_t p2);
    apply(3'h0, {4'h0, col, 2'h0}, {1'b0, bpc, 4'h0});
    @(posedge clk);
    pix_valid <= 1'b1;
    pix_rgb   <= p1;
    @(posedge clk);
    pix_rgb <= p2;
    #1;
    check(pix_out_ff, want_pix(col, bpc, p1));
    @(posedge clk);
    pix_valid <= 1'b0;
    #1;
    check(pix_out_ff, want_pix(col, bpc, p2));
    check(24'(pix_out_valid_ff), 24'h000001);
    @(posedge clk);
    #1;
    check(24'(pix_out_valid_ff), 24'h000000);
    check(pix_out_ff, want_pix(col, bpc, p2));
  endtask

  // Recommended software settings for the common panel kinds
  task automatic t_sw_cfg();
    apply(3'h0, 8'h0c, 8'h60);
    check(24'({frc_mode, level_exp}), 24'h000006);
    apply(3'h0, 8'h0c, 8'h42);
    check(24'({frc_mode, level_exp}), 24'h000024);
    apply(3'h4, 8'h00, 8'h41);
    check(24'({frc_mode, level_exp}), 24'h000014);
  endtask

  // Legal codes give 64 >> code pulses per window; illegal ones hold both low
  task automatic div_case(input logic [2:0] tech, input logic dual, input logic [1:0] col,
                          input logic [2:0] code, input logic legal);
    apply(tech, {1'b0, code, col, dual, dual}, 8'h00);
    @(posedge clk);
    cnt_clr <= 1'b1;
    @(posedge clk);
    cnt_clr <= 1'b0;
    repeat (64) @(posedge clk);
    #1;
    check(24'(div_valid), 24'(legal));
    check(24'(pulse_cnt), legal ? 24'(8'h40 >> code) : 24'h000000);
    check(24'(high_cnt), legal ? ((code == 3'h0) ? 24'h40 : 24'h20) : 24'h0);
  endtask

  initial
  begin
    clk = 1'b0;
    arst_n = 1'b0;
    {io_addr, io_wr, io_rd, io_wdata} = '0;
    {panel_is_stn, frame_accel_en, pack_4bit, high_color_mode, frame_start} = '0;
    {pix_valid, pix_rgb, cnt_clr} = '0;
    error_cnt = 0;
    n_compared = 0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_regs();
    t_fields();
    t_restrict();
    t_sw_cfg();
    t_pix(2'h3, 3'h7, 24'h12a5f0, 24'hff0180);
    t_pix(2'h3, 3'h4, 24'h9c3e71, 24'h0fe8c6);
    t_pix(2'h0, 3'h7, 24'hc83264, 24'hffffff);
    t_pix(2'h1, 3'h5, 24'h80ff10, 24'h5a5a5a);
    t_pix(2'h2, 3'h6, 24'h11e7c3, 24'hfe02fd);
    div_case(3'h0, 1'b0, 2'h0, 3'h0, 1'b1);
    div_case(3'h0, 1'b0, 2'h0, 3'h4, 1'b1);
    div_case(3'h0, 1'b0, 2'h0, 3'h5, 1'b0);
    div_case(3'h0, 1'b0, 2'h3, 3'h1, 1'b1);
    div_case(3'h0, 1'b0, 2'h3, 3'h2, 1'b0);
    div_case(3'h5, 1'b0, 2'h3, 3'h2, 1'b1);
    div_case(3'h5, 1'b0, 2'h3, 3'h3, 1'b0);
    div_case(3'h6, 1'b1, 2'h0, 3'h3, 1'b1);
    div_case(3'h6, 1'b1, 2'h0, 3'h4, 1'b0);
    div_case(3'h4, 1'b1, 2'h0, 3'h0, 1'b0);
    div_case(3'h4, 1'b1, 2'h0, 3'h4, 1'b1);
    div_case(3'h7, 1'b1, 2'h3, 3'h1, 1'b1);
    div_case(3'h7, 1'b1, 2'h3, 3'h2, 1'b0);
    div_case(3'h5, 1'b1, 2'h3, 3'h0, 1'b0);
    div_case(3'h5, 1'b1, 2'h3, 3'h2, 1'b1);
    div_case(3'h6, 1'b1, 2'h3, 3'h2, 1'b1);
    div_case(3'h6, 1'b1, 2'h3, 3'h3, 1'b0);
    div_case(3'h4, 1'b1, 2'h3, 3'h0, 1'b0);
    div_case(3'h4, 1'b1, 2'h3, 3'h3, 1'b1);
    end_sim();
  end

  // Full run is about 1,800 cycles; the 25,000-cycle limit allows over ten times that
  initial
  begin
    #1000000;
    error_cnt++;
    end_sim();
  end
endmodule // testbench
